// [wreg_pkg.sv]
// Package for the working register address generator: register map and reset values.
// Assumes an 8-bit register file addressed by the instruction decoder.
// Operation
// RULE1: Slice pointers live at set 1 addresses d6 and d7, direct-addressable.
// RULE2: Reset puts first pointer at c0-c7 and second at c8-cf.
// RULE3: Operand bit 3 picks pointer: zero first, one second.
// RULE4: Pointer upper five bits become address upper five bits.
// RULE5: Operand low three bits become address low three bits.
// RULE6: Combined set loads value into first pointer, value plus 8 into second.
// RULE7: Single set instructions change only their own pointer.
// RULE8: Load and clear to pointer addresses write pointers directly.
// RULE9: Working register accesses never land in set 2.
// RULE10: Pointers are independent; slices may be non-contiguous or swapped.
// RULE11: Register pairs need even address; high byte even, low byte odd.
// RULE12: Direct register addressing reaches everything except set 2.
// RULE13: Software reaches common area c0-cf only via working register addressing.
// RULE14: Common working area is reachable regardless of register page.
// RULE15: Eight-bit operand with upper nibble 1100 acts as 4-bit working address.
// RULE16: Low three pointer bits are ignored when forming addresses.
// RULE17: Pointer writes affect address generation from the next instruction.
package wreg_pkg;
   localparam logic [7:0] FIRST_PTR_ADDR = 8'hd6;
   localparam logic [7:0] SECOND_PTR_ADDR = 8'hd7;
   localparam logic [7:0] FIRST_PTR_RST = 8'hc0;
   localparam logic [7:0] SECOND_PTR_RST = 8'hc8;
   localparam logic [7:0] SLICE_STEP = 8'h08;
   localparam logic [3:0] WORK_NIBBLE = 4'hc;
   localparam logic [7:0] COMMON_LO = 8'hc0;
   localparam logic [7:0] COMMON_HI = 8'hcf;
   localparam int SLICE_MSB = 7;
   localparam int SLICE_LSB = 3;
   typedef enum logic [1:0] {
      PSET_NONE,
      PSET_BOTH,
      PSET_FIRST,
      PSET_SECOND
   } pset_t;
endpackage : wreg_pkg

// [working_register_address_gen.sv]
// Working register address generator: slice pointers and operand address expansion.
// Assumes the decoder presents one operand per cycle and strobes writes for one cycle.
`timescale 1ns/10ps
module working_register_address_gen
   import wreg_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Pointer-set instructions from the decoder.
   input wire pset_t pset_op_i,
   input wire logic [7:0] pset_val_i,
   // Direct register write (load or clear) from the decoder.
   input wire logic dir_wr_i,
   input wire logic [7:0] dir_addr_i,
   input wire logic [7:0] dir_wdata_i,
   // Operand to resolve.
   input wire logic opnd_long_i,
   input wire logic [7:0] opnd_i,
   input wire logic opnd_pair_i,
   // Resolved address to the register file.
   output logic [7:0] reg_addr_o,
   output logic set1_o,
   output logic working_o,
   output logic pair_odd_err_o,
   output logic dir_common_err_o,
   // Pointer read-back.
   output logic [7:0] first_ptr_o,
   output logic [7:0] second_ptr_o
);
   logic rst_s1_r, rst_n_r;
   logic [7:0] first_ptr_r, first_ptr_nxt;
   logic [7:0] second_ptr_r, second_ptr_nxt;
   logic [7:0] addr_nxt;
   logic set1_nxt, working_nxt, pair_err_nxt, common_err_nxt;
   logic [3:0] wnib;
   logic is_work;

   // Builds a register address from a slice pointer and a slot number inside that slice.
   function automatic logic [7:0] slice_addr(input logic [7:0] ptr, input logic [2:0] slot);
      return {ptr[SLICE_MSB:SLICE_LSB], slot};
   endfunction : slice_addr

   function automatic logic in_common(input logic [7:0] addr);
      return addr >= COMMON_LO && addr <= COMMON_HI;
   endfunction : in_common

   // The release waits two edges so that no flop leaves reset on the edge where the pin rises.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // Direct writes are applied after set instructions, so a same-cycle clash favours the store.
   always_comb begin
      first_ptr_nxt = first_ptr_r;
      second_ptr_nxt = second_ptr_r;
      unique case (pset_op_i)
         PSET_NONE: ;
         PSET_BOTH: begin
            first_ptr_nxt = pset_val_i; // [RULE6]
            second_ptr_nxt = 8'(pset_val_i + SLICE_STEP); // [RULE6] [RULE10]
         end
         PSET_FIRST: first_ptr_nxt = pset_val_i; // [RULE7]
         PSET_SECOND: second_ptr_nxt = pset_val_i; // [RULE7]
      endcase
      if (dir_wr_i && dir_addr_i == FIRST_PTR_ADDR) begin
         first_ptr_nxt = dir_wdata_i; // [RULE1] [RULE8]
      end
      if (dir_wr_i && dir_addr_i == SECOND_PTR_ADDR) begin
         second_ptr_nxt = dir_wdata_i; // [RULE1] [RULE8]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         first_ptr_r <= FIRST_PTR_RST; // [RULE2]
         second_ptr_r <= SECOND_PTR_RST; // [RULE2]
      end else begin
         first_ptr_r <= first_ptr_nxt; // [RULE17]
         second_ptr_r <= second_ptr_nxt;
      end
   end

   // Set 1 versus set 2 is carried on set1_o; page selection is not applied here.
   always_comb begin
      is_work = !opnd_long_i || (opnd_i[7:4] == WORK_NIBBLE); // [RULE15]
      wnib = opnd_i[3:0];
      if (is_work) begin
         // Pointer low bits dropped; result is always set 1 or prime. [RULE9] [RULE16]
         addr_nxt = slice_addr(wnib[3] ? second_ptr_r : first_ptr_r, // [RULE3] [RULE4]
                               wnib[2:0]); // [RULE5]
         set1_nxt = 1'b1; // [RULE14]
      end else begin
         addr_nxt = opnd_i;
         set1_nxt = 1'b1; // [RULE12]
      end
      working_nxt = is_work;
      pair_err_nxt = opnd_pair_i && addr_nxt[0]; // [RULE11]
      // A short or 1100 operand is always working, so only a direct store can misuse the area.
      common_err_nxt = dir_wr_i && in_common(dir_addr_i); // [RULE13]
   end

   // Outputs are registered so the register file sees a steady address for a whole cycle;
   // the price is one cycle of latency between operand and address.
   always_ff @(posedge mclk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reg_addr_o <= 8'h00;
         set1_o <= 1'b0;
         working_o <= 1'b0;
         pair_odd_err_o <= 1'b0;
         dir_common_err_o <= 1'b0;
      end else begin
         reg_addr_o <= addr_nxt;
         set1_o <= set1_nxt;
         working_o <= working_nxt;
         pair_odd_err_o <= pair_err_nxt;
         dir_common_err_o <= common_err_nxt;
      end
   end

   assign first_ptr_o = first_ptr_r;
   assign second_ptr_o = second_ptr_r;

   a_both_set: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE6]
      (pset_op_i == PSET_BOTH && !dir_wr_i) |=> (first_ptr_r == $past(pset_val_i)
      && second_ptr_r == 8'($past(pset_val_i) + SLICE_STEP)))
      else $error("combined set wrong");
   a_first_only: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE7]
      (pset_op_i == PSET_FIRST && !dir_wr_i) |=> $stable(second_ptr_r))
      else $error("second pointer moved");
   a_second_only: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE7]
      (pset_op_i == PSET_SECOND && !dir_wr_i) |=> $stable(first_ptr_r))
      else $error("first pointer moved");
   a_direct_write: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE8]
      (dir_wr_i && dir_addr_i == SECOND_PTR_ADDR) |=> second_ptr_r == $past(dir_wdata_i))
      else $error("direct write lost");
   a_addr_low: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE5]
      (!opnd_long_i) |=> reg_addr_o[2:0] == $past(opnd_i[2:0]))
      else $error("low bits wrong");
   a_addr_high: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE3]
      (!opnd_long_i && opnd_i[3]) |=> reg_addr_o[7:3] == $past(second_ptr_r[7:3]))
      else $error("second slice wrong");
   a_long_work: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE15]
      (opnd_long_i && opnd_i[7:4] == WORK_NIBBLE && !opnd_i[3])
      |=> reg_addr_o == {$past(first_ptr_r[7:3]), $past(opnd_i[2:0])})
      else $error("long working address wrong");
   a_pair_odd: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE11]
      working_o |-> (pair_odd_err_o == ($past(opnd_pair_i) && reg_addr_o[0])))
      else $error("pair check wrong");
   a_next_instr: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE17]
      (pset_op_i == PSET_FIRST && !dir_wr_i) ##1 (!opnd_long_i && !opnd_i[3])
      |=> reg_addr_o[7:3] == $past(pset_val_i[7:3], 2))
      else $error("pointer update late");
   // A clear arrives as a direct write of zero, so it shares the load path.
   a_first_direct: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE8]
      (dir_wr_i && dir_addr_i == FIRST_PTR_ADDR) |=> first_ptr_r == $past(dir_wdata_i))
      else $error("first pointer direct write lost");
   a_first_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE8]
      (pset_op_i == PSET_FIRST && dir_wr_i && dir_addr_i == FIRST_PTR_ADDR)
      |=> first_ptr_r == $past(dir_wdata_i))
      else $error("store lost against single set");
   a_store_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE8]
      (pset_op_i == PSET_BOTH && dir_wr_i && dir_addr_i == SECOND_PTR_ADDR)
      |=> second_ptr_r == $past(dir_wdata_i) && first_ptr_r == $past(pset_val_i))
      else $error("store lost against combined set");
   a_first_value: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE7]
      (pset_op_i == PSET_FIRST && !dir_wr_i) |=> first_ptr_r == $past(pset_val_i))
      else $error("first pointer not loaded");
   a_second_value: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE7]
      (pset_op_i == PSET_SECOND && !dir_wr_i) |=> second_ptr_r == $past(pset_val_i))
      else $error("second pointer not loaded");
   a_idle_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE17]
      (pset_op_i == PSET_NONE && !dir_wr_i) |=> $stable(first_ptr_r) && $stable(second_ptr_r))
      else $error("pointer moved while idle");
   a_foreign_store: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE1]
      (pset_op_i == PSET_NONE && dir_wr_i && dir_addr_i != FIRST_PTR_ADDR
      && dir_addr_i != SECOND_PTR_ADDR) |=> $stable(first_ptr_r) && $stable(second_ptr_r))
      else $error("pointer moved on a foreign store");

   // The output flops still sit in reset on the release edge, so a_first_slice and a_short_flag start one later.
   a_first_slice: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE16]
      (rst_n_r && !opnd_long_i && !opnd_i[3])
      |=> reg_addr_o == slice_addr($past(first_ptr_r), $past(opnd_i[2:0])))
      else $error("first slice address wrong");
   a_long_second: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE15]
      (opnd_long_i && opnd_i[7:4] == WORK_NIBBLE && opnd_i[3])
      |=> reg_addr_o == slice_addr($past(second_ptr_r), $past(opnd_i[2:0])))
      else $error("long working address to second slice wrong");
   a_long_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE15]
      (opnd_long_i && opnd_i[7:4] == WORK_NIBBLE) |=> working_o)
      else $error("long working operand not flagged");
   a_short_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE14]
      (rst_n_r && !opnd_long_i) |=> working_o && set1_o)
      else $error("short operand not resolved as working");
   a_direct_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE12]
      (opnd_long_i && opnd_i[7:4] != WORK_NIBBLE) |=> reg_addr_o == $past(opnd_i) && !working_o)
      else $error("direct address altered");

   // Error flags only report; the access itself still reaches the register file.
   a_pair_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE11]
      (!opnd_pair_i) |=> !pair_odd_err_o)
      else $error("pair error without a pair");
   a_pair_even: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE11]
      (opnd_pair_i && !opnd_long_i && !opnd_i[0]) |=> !pair_odd_err_o)
      else $error("even working pair flagged");
   a_pair_direct: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE11]
      (opnd_pair_i && opnd_long_i && opnd_i[7:4] != WORK_NIBBLE)
      |=> pair_odd_err_o == $past(opnd_i[0]))
      else $error("direct pair parity wrong");
   a_common_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE13]
      (dir_wr_i && in_common(dir_addr_i)) |=> dir_common_err_o)
      else $error("common area store not flagged");
   a_common_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_r) // [RULE13]
      (!dir_wr_i) |=> !dir_common_err_o)
      else $error("common area flag without a store");

   c_both: cover property (@(posedge mclk_i) pset_op_i == PSET_BOTH);
   c_long: cover property (@(posedge mclk_i) working_o && reg_addr_o[7:4] != 4'hc);
   c_err: cover property (@(posedge mclk_i) dir_common_err_o);
   c_pair: cover property (@(posedge mclk_i) pair_odd_err_o);
   c_apart: cover property (@(posedge mclk_i) second_ptr_r[7:3] != first_ptr_r[7:3] + 5'h01);
endmodule : working_register_address_gen

// [wrg_decoder_model.sv]
// Decoder model: drives one instruction's fields per cycle into the address generator.
// Assumes every issue starts on a falling clock edge.
`timescale 1ns/10ps
module wrg_decoder_model
   import wreg_pkg::*;
(
   // Clock.
   input wire logic mclk_i,
   // Instruction fields.
   output pset_t pset_op_o,
   output logic [7:0] pset_val_o,
   output logic dir_wr_o,
   output logic [7:0] dir_addr_o,
   output logic [7:0] dir_wdata_o,
   output logic opnd_long_o,
   output logic [7:0] opnd_o,
   output logic opnd_pair_o
);
   // Every issue replaces all fields, so a write strobe never lasts past its own cycle.
   task automatic issue(input pset_t k, input logic [7:0] v, input logic w,
      input logic [7:0] a, input logic [7:0] d, input logic lng, input logic [7:0] o,
      input logic pr);
      pset_op_o = k;
      {pset_val_o, dir_wr_o, dir_addr_o, dir_wdata_o} = {v, w, a, d};
      {opnd_long_o, opnd_o, opnd_pair_o} = {lng, o, pr};
      @(negedge mclk_i);
   endtask : issue
   initial issue(PSET_NONE, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
endmodule : wrg_decoder_model

// [tb_working_register_address_gen.sv]
// Testbench for the working register address generator, with a reference pointer model.
// Assumes outputs settle on the rising edge that samples the operand, half a cycle before the check.
`timescale 1ns/10ps
module tb_working_register_address_gen;
   import wreg_pkg::*;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   pset_t op;
   logic [7:0] val, da, dd, opnd, ra, fp, sp, p0, p1, o, v, wa, x8, d8;
   logic dw, lng, pr, s1, wk, oe, ce;
   logic [8:0] e;
   int err_count = 0;
   int n_compared = 0;
   int seed = 71;
   always #2 mclk_i = ~mclk_i;
   wrg_decoder_model dec(.mclk_i(mclk_i), .pset_op_o(op), .pset_val_o(val), .dir_wr_o(dw),
      .dir_addr_o(da), .dir_wdata_o(dd), .opnd_long_o(lng), .opnd_o(opnd), .opnd_pair_o(pr));
   working_register_address_gen uut(.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pset_op_i(op),
      .pset_val_i(val), .dir_wr_i(dw), .dir_addr_i(da), .dir_wdata_i(dd), .opnd_long_i(lng),
      .opnd_i(opnd), .opnd_pair_i(pr), .reg_addr_o(ra), .set1_o(s1), .working_o(wk),
      .pair_odd_err_o(oe), .dir_common_err_o(ce), .first_ptr_o(fp), .second_ptr_o(sp));
   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // Bit 8 is the working flag; the pointer's low three bits never reach the address.
   function automatic logic [8:0] exp_addr(input logic l, input logic [7:0] a);
      if (!l || a[7:4] == WORK_NIBBLE) return {1'b1, (a[3] ? p1 : p0) & 8'hf8 | {5'h0, a[2:0]}};
      return {1'b0, a};
   endfunction : exp_addr
   task automatic setp(input pset_t k, input logic [7:0] x, input logic w,
      input logic [7:0] a, input logic [7:0] d);
      dec.issue(k, x, w, a, d, 1'b0, 8'h00, 1'b0);
      if (k == PSET_BOTH) {p0, p1} = {x, x + SLICE_STEP};
      if (k == PSET_FIRST) p0 = x;
      if (k == PSET_SECOND) p1 = x;
      if (w && a == FIRST_PTR_ADDR) p0 = d;
      if (w && a == SECOND_PTR_ADDR) p1 = d;
      check("first_ptr", fp, p0);
      check("second_ptr", sp, p1);
      check("common_err", {7'h0, ce}, {7'h0, w && a >= COMMON_LO && a <= COMMON_HI});
   endtask : setp
   task automatic rd(input logic l, input logic [7:0] a, input logic p);
      e = exp_addr(l, a);
      dec.issue(PSET_NONE, 8'h00, 1'b0, 8'h00, 8'h00, l, a, p);
      check("reg_addr", ra, e[7:0]);
      check("working", {7'h0, wk}, {7'h0, e[8]});
      check("set1", {7'h0, s1}, 8'h01);
      check("pair_odd", {7'h0, oe}, {7'h0, p & e[0]});
      check("common_err", {7'h0, ce}, 8'h00);
   endtask : rd
   initial begin
      #20000;
      err_count++;
      finish_test();
   end
   initial begin
      {p0, p1} = {FIRST_PTR_RST, SECOND_PTR_RST};
      repeat (2) @(negedge mclk_i);
      arst_n_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      check("rst_first", fp, p0);
      check("rst_second", sp, p1);
      rd(1'b0, 8'h06, 1'b0);
      rd(1'b0, 8'h0f, 1'b1);
      setp(PSET_BOTH, 8'h70, 1'b0, 8'h00, 8'h00);
      rd(1'b0, 8'h06, 1'b0);
      setp(PSET_SECOND, 8'h48, 1'b0, 8'h00, 8'h00);
      setp(PSET_FIRST, 8'ha0, 1'b0, 8'h00, 8'h00);
      setp(PSET_NONE, 8'h00, 1'b1, FIRST_PTR_ADDR, 8'h00);
      setp(PSET_NONE, 8'h00, 1'b1, SECOND_PTR_ADDR, 8'hf8);
      setp(PSET_NONE, 8'h00, 1'b1, 8'h55, 8'h12);
      setp(PSET_NONE, 8'h00, 1'b1, 8'hc2, 8'h40);
      setp(PSET_BOTH, 8'h33, 1'b1, SECOND_PTR_ADDR, 8'h9d);
      rd(1'b1, 8'hcb, 1'b0);
      repeat (200) begin
         v = 8'($random(seed));
         o = 8'($random(seed));
         x8 = 8'($random(seed));
         d8 = 8'($random(seed));
         wa = o[0] ? FIRST_PTR_ADDR : (o[1] ? SECOND_PTR_ADDR : v);
         if (wa[7:4] == WORK_NIBBLE) wa[7:4] = 4'h8;
         setp(pset_t'(v[1:0]), x8, o[2], wa, d8);
         if (o[7:4] == 4'hd) o[7:4] = WORK_NIBBLE;
         rd(v[2], o, v[3]);
      end
      finish_test();
   end
endmodule : tb_working_register_address_gen
